/* File: rtl/crt_pkg.sv */
// Shared constants of the raster timing core: ports, indices, fields, offsets
package crt_pkg;
  // ----------------------------------------------------------------
  // Host port addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] CRT_MONO_INDEX_PORT = 16'h03B4;
  localparam logic [15:0] CRT_MONO_DATA_PORT = 16'h03B5;
  localparam logic [15:0] CRT_COLOR_INDEX_PORT = 16'h03D4;
  localparam logic [15:0] CRT_COLOR_DATA_PORT = 16'h03D5;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] CRT_IDX_LINE_TOTAL = 5'h00;
  localparam logic [4:0] CRT_IDX_ACTIVE_END = 5'h01;
  localparam logic [4:0] CRT_IDX_BLANK_START = 5'h02;
  localparam logic [4:0] CRT_IDX_BLANK_END = 5'h03;
  localparam logic [4:0] CRT_IDX_SYNC_START = 5'h04;
  localparam logic [4:0] CRT_IDX_SYNC_END = 5'h05;
  localparam logic [4:0] CRT_IDX_FRAME_TOTAL = 5'h06;
  localparam logic [4:0] CRT_IDX_VERT_HIGH = 5'h07;
  localparam logic [4:0] CRT_IDX_ROW_PRESET = 5'h08;
  localparam logic [4:0] CRT_IDX_ROW_HEIGHT = 5'h09;
  localparam logic [4:0] CRT_IDX_SYNC_PROTECT = 5'h11;
  localparam int CRT_NUM_TIMING_REGS = 10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CRT_INDEX_KEEP_MSB = 5;
  localparam int CRT_SKEW_HI = 6;
  localparam int CRT_SKEW_LO = 5;
  localparam int CRT_BLANK_END_B5_POS = 7;
  localparam int CRT_END_LOW_MSB = 4;
  localparam int CRT_VT_B8_POS = 0;
  localparam int CRT_VT_B9_POS = 5;
  localparam int CRT_OVF_UNPROT_POS = 4;
  localparam int CRT_PROTECT_POS = 7;
  localparam int CRT_DOUBLE_SCAN_POS = 7;
  localparam int CRT_ROW_MSB = 4;

  // ----------------------------------------------------------------
  // Counts, offsets and the unmapped read value
  // ----------------------------------------------------------------
  localparam logic [8:0] CRT_HTOTAL_OFFSET = 9'h004;
  localparam logic [9:0] CRT_VTOTAL_OFFSET = 10'h001;
  localparam int CRT_SKEW_DEPTH = 3;
  localparam logic [7:0] CRT_READ_UNMAPPED = 8'h00;
endpackage

/* File: rtl/crt_raster_timing_core.sv */
// Indexed timing registers, horizontal and row scan counters of the raster core
//
// Behaviour
// - Index low five bits select data register
// - Line total is characters minus five
// - Character counter compared against registers
// - Active width is displayed characters minus one
// - Blanking starts at blank-start match
// - Blanking ends on six-bit low match
// - Display enable skew of 0..3 clocks
// - Retrace starts at programmed character position
// - Retrace ends on five-bit low match
// - Retrace skew field, code 00 no delay
// - Ten-bit frame total is lines minus two
// - Overflow register carries vertical high bits
// - Row scan loads preset after frame
// - Row scan steps per line, clears at max
// - Preset bits 6:5 extend pixel panning
// - Double scan halves row scan clock
// - Row height field gives maximum row scan
// - Ports at mono or colour base
// - Protect bit blocks writes to 0..7, bit 4 of 7 excepted
`timescale 1ns/100ps
module crt_raster_timing_core #(
  parameter int HCNT_W = 9
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic char_ce,
  input wire logic color_base_sel,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic hblank,
  output logic hsync,
  output logic disp_en,
  output logic [4:0] row_scan,
  output logic [9:0] line_count,
  output logic [1:0] pixel_shift_offset
);
  import crt_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CRT_INDEX_KEEP_MSB:0] index;
    logic [CRT_NUM_TIMING_REGS-1:0][7:0] regs;
    logic [7:0] sync_protect;
    logic [HCNT_W-1:0] hcnt;
    logic de_raw;
    logic blank;
    logic sync_raw;
    logic [9:0] line;
    logic [4:0] row;
    logic half;
    logic [7:0] rdata;
  } crt_state_s;

  crt_state_s s_reg;
  crt_state_s s_next;

  // Largest total plus offset must fit the counter
  if (HCNT_W != 9) begin : g_bad_hcnt
    $error("crt_raster_timing_core: HCNT_W must be 9");
  end

  logic [15:0] index_port;
  logic [15:0] data_port;
  logic [4:0] sel;
  logic [HCNT_W-1:0] htot_end;
  logic [HCNT_W-1:0] hcnt_nx;
  logic [5:0] blank_end6;
  logic [9:0] vt_end;
  logic line_tick;
  logic dbl;
  logic protect;
  logic [7:0] rd_mux;

  // ----------------------------------------------------------------
  // Decode and derived timing values
  // ----------------------------------------------------------------
  // Base chosen by the external miscellaneous-output bit
  assign index_port = color_base_sel ? CRT_COLOR_INDEX_PORT : CRT_MONO_INDEX_PORT;
  assign data_port = color_base_sel ? CRT_COLOR_DATA_PORT : CRT_MONO_DATA_PORT;
  assign sel = s_reg.index[4:0];
  assign htot_end = {1'b0, s_reg.regs[CRT_IDX_LINE_TOTAL]} + CRT_HTOTAL_OFFSET;
  assign blank_end6 = {s_reg.regs[CRT_IDX_SYNC_END][CRT_BLANK_END_B5_POS],
                       s_reg.regs[CRT_IDX_BLANK_END][CRT_END_LOW_MSB:0]};
  // Frame of total+2 lines counts 0..total+1
  assign vt_end = {s_reg.regs[CRT_IDX_VERT_HIGH][CRT_VT_B9_POS],
                   s_reg.regs[CRT_IDX_VERT_HIGH][CRT_VT_B8_POS],
                   s_reg.regs[CRT_IDX_FRAME_TOTAL]} + CRT_VTOTAL_OFFSET;
  assign line_tick = (s_reg.hcnt == {1'b0, s_reg.regs[CRT_IDX_SYNC_START]});
  assign dbl = s_reg.regs[CRT_IDX_ROW_HEIGHT][CRT_DOUBLE_SCAN_POS];
  assign protect = s_reg.sync_protect[CRT_PROTECT_POS];
  assign hcnt_nx = (s_reg.hcnt == htot_end) ? '0 : s_reg.hcnt + 1'b1;

  // Read mux; indices outside the set answer a fixed value
  always_comb begin
    rd_mux = CRT_READ_UNMAPPED;
    if (sel < 5'(CRT_NUM_TIMING_REGS)) begin
      rd_mux = s_reg.regs[sel[3:0]];
    end else if (sel == CRT_IDX_SYNC_PROTECT) begin
      rd_mux = s_reg.sync_protect;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Whole block, host port included, advances only on character clocks
  always_comb begin
    s_next = s_reg;
    if (char_ce) begin
      // Host port
      if (io_wr && io_addr == index_port) begin
        s_next.index = io_wdata[CRT_INDEX_KEEP_MSB:0];
      end
      if (io_wr && io_addr == data_port) begin
        if (sel < 5'(CRT_NUM_TIMING_REGS)) begin
          if (!protect || sel > CRT_IDX_VERT_HIGH) begin
            s_next.regs[sel[3:0]] = io_wdata;
          end else if (sel == CRT_IDX_VERT_HIGH) begin
            // Line-compare bit stays writable under protection
            s_next.regs[CRT_IDX_VERT_HIGH][CRT_OVF_UNPROT_POS] =
              io_wdata[CRT_OVF_UNPROT_POS];
          end
        end else if (sel == CRT_IDX_SYNC_PROTECT) begin
          s_next.sync_protect = io_wdata;
        end
      end
      if (io_rd && io_addr == index_port) begin
        s_next.rdata = {2'b00, s_reg.index};
      end else if (io_rd && io_addr == data_port) begin
        s_next.rdata = rd_mux;
      end

      // Horizontal counter and comparators
      s_next.hcnt = hcnt_nx;
      s_next.de_raw = (hcnt_nx <= {1'b0, s_reg.regs[CRT_IDX_ACTIVE_END]});
      // End match wins so a zero-width setting never sticks on
      if (s_reg.hcnt[5:0] == blank_end6) begin
        s_next.blank = 1'b0;
      end else if (s_reg.hcnt == {1'b0, s_reg.regs[CRT_IDX_BLANK_START]}) begin
        s_next.blank = 1'b1;
      end
      if (s_reg.hcnt[4:0] == s_reg.regs[CRT_IDX_SYNC_END][CRT_END_LOW_MSB:0]) begin
        s_next.sync_raw = 1'b0;
      end else if (line_tick) begin
        s_next.sync_raw = 1'b1;
      end

      // Line and row scan counters step at retrace start
      if (line_tick) begin
        if (s_reg.line == vt_end) begin
          s_next.line = '0;
          s_next.row = s_reg.regs[CRT_IDX_ROW_PRESET][CRT_ROW_MSB:0];
          s_next.half = 1'b0;
        end else begin
          s_next.line = s_reg.line + 1'b1;
          s_next.half = dbl ? ~s_reg.half : 1'b0;
          if (!dbl || s_reg.half) begin
            // Clear, not preset, at maximum
            if (s_reg.row == s_reg.regs[CRT_IDX_ROW_HEIGHT][CRT_ROW_MSB:0]) begin
              s_next.row = '0;
            end else begin
              s_next.row = s_reg.row + 1'b1;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Skew lines and outputs
  // ----------------------------------------------------------------
  // Enable skew covers memory, font and panning latency
  crt_skew_line #(.DEPTH(CRT_SKEW_DEPTH), .SEL_W(2)) u_de_skew (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .char_ce(char_ce),
    .sig_in(s_reg.de_raw),
    .skew_sel(s_reg.regs[CRT_IDX_BLANK_END][CRT_SKEW_HI:CRT_SKEW_LO]),
    .sig_out(disp_en)
  );

  crt_skew_line #(.DEPTH(CRT_SKEW_DEPTH), .SEL_W(2)) u_sync_skew (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .char_ce(char_ce),
    .sig_in(s_reg.sync_raw),
    .skew_sel(s_reg.regs[CRT_IDX_SYNC_END][CRT_SKEW_HI:CRT_SKEW_LO]),
    .sig_out(hsync)
  );

  assign io_rdata = s_reg.rdata;
  assign hblank = s_reg.blank;
  assign row_scan = s_reg.row;
  assign line_count = s_reg.line;
  // Only meaningful in multiple-shift modes; normally zero
  assign pixel_shift_offset = s_reg.regs[CRT_IDX_ROW_PRESET][CRT_SKEW_HI:CRT_SKEW_LO];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic wr_data;
  assign wr_data = char_ce && io_wr && io_addr == data_port;

  a_index_load: assert property (char_ce && io_wr && io_addr == index_port
    |=> s_reg.index[4:0] == $past(io_wdata[4:0]))
    else $error("index not loaded from low bits");
  a_hcnt_wrap: assert property (char_ce && s_reg.hcnt == htot_end |=> s_reg.hcnt == '0
    ##0 s_reg.de_raw == 1'b1)
    else $error("counter did not wrap at total");
  a_hcnt_step: assert property (char_ce && s_reg.hcnt != htot_end
    |=> s_reg.hcnt == $past(s_reg.hcnt) + 1'b1)
    else $error("counter did not step");
  a_blank_start: assert property (char_ce && s_reg.hcnt == {1'b0, s_reg.regs[2]}
    && s_reg.hcnt[5:0] != blank_end6 |=> hblank)
    else $error("blanking did not start");
  a_blank_end: assert property (char_ce && s_reg.hcnt[5:0] == blank_end6 |=> !hblank)
    else $error("blanking did not end");
  a_sync_start: assert property (char_ce && line_tick
    && s_reg.hcnt[4:0] != s_reg.regs[5][4:0] |=> s_reg.sync_raw)
    else $error("retrace did not start");
  a_sync_end: assert property (char_ce && s_reg.hcnt[4:0] == s_reg.regs[5][4:0]
    |=> !s_reg.sync_raw)
    else $error("retrace did not end");
  a_sync_noskew: assert property (s_reg.regs[5][6:5] == 2'b00 |-> hsync == s_reg.sync_raw)
    else $error("retrace skewed with code zero");
  a_de_skew_one: assert property (s_reg.regs[3][6:5] == 2'b01 && char_ce
    ##1 s_reg.regs[3][6:5] == 2'b01 |-> disp_en == $past(s_reg.de_raw))
    else $error("display enable skew wrong");
  a_protect_hold: assert property (wr_data && protect && sel < CRT_IDX_VERT_HIGH
    |=> s_reg.regs == $past(s_reg.regs))
    else $error("protected register written");
  a_row_preset: assert property (char_ce && line_tick && s_reg.line == vt_end
    |=> s_reg.row == $past(s_reg.regs[8][4:0]) && s_reg.line == '0)
    else $error("row scan not preset at frame end");
  a_row_clear: assert property (char_ce && line_tick && s_reg.line != vt_end && !dbl
    && s_reg.row == s_reg.regs[9][4:0] |=> s_reg.row == '0)
    else $error("row scan not cleared at maximum");
  a_row_double: assert property (char_ce && line_tick && s_reg.line != vt_end && dbl
    && !s_reg.half |=> $stable(s_reg.row))
    else $error("double scan stepped row early");

  c_frame_wrap: cover property (char_ce && line_tick && s_reg.line == vt_end);
  c_protect_write: cover property (wr_data && protect && sel == CRT_IDX_VERT_HIGH);
  c_double_scan: cover property (dbl && char_ce && line_tick && s_reg.half);
  c_skewed_sync: cover property (s_reg.regs[5][6:5] == 2'b11 && $rose(hsync));
endmodule

/* File: rtl/crt_skew_line.sv */
// Selectable delay line that skews a timing signal by whole character clocks
`timescale 1ns/100ps
module crt_skew_line #(
  parameter int DEPTH = crt_pkg::CRT_SKEW_DEPTH,
  parameter int SEL_W = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic char_ce,
  input wire logic sig_in,
  input wire logic [SEL_W-1:0] skew_sel,
  output logic sig_out
);
  import crt_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0] taps;
  } crt_skew_s;

  crt_skew_s s_reg;
  crt_skew_s s_next;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Every nonzero select code needs its own tap
  if (DEPTH < (1 << SEL_W) - 1 || DEPTH < 2) begin : g_bad_depth
    $error("crt_skew_line: DEPTH too small for SEL_W");
  end

  // Shift one tap per character clock
  always_comb begin
    s_next = s_reg;
    if (char_ce) begin
      s_next.taps = {s_reg.taps[DEPTH-2:0], sig_in};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Code zero passes the already registered input straight through
  assign sig_out = (skew_sel == '0) ? sig_in : s_reg.taps[int'(skew_sel) - 1];
endmodule

/* File: sim/crt_monitor_model.sv */
// Display-side model that measures the line timing it receives
`timescale 1ns/100ps
module crt_monitor_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsync,
  input wire logic hblank,
  input wire logic disp_en,
  output logic [15:0] line_period,
  output logic [15:0] sync_width,
  output logic [15:0] en_width,
  output logic [15:0] blank_width,
  output logic [15:0] sync_lag,
  output logic [15:0] en_lag
);
  logic [15:0] cyc, t_sr, t_br, t_bf, t_er;
  logic hs_q, hb_q, en_q;

  // ----------------------------------------------------------------
  // Edge stamps
  // ----------------------------------------------------------------
  // Every figure is a difference of two stamps, so a wrapped cycle count still works
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc <= '0;
      hs_q <= 1'b0;
      hb_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      cyc <= cyc + 16'h0001;
      hs_q <= hsync;
      hb_q <= hblank;
      en_q <= disp_en;
      if (hsync && !hs_q) begin
        line_period <= cyc - t_sr;
        sync_lag <= cyc - t_br;
        t_sr <= cyc;
      end
      if (!hsync && hs_q) sync_width <= cyc - t_sr;
      if (hblank && !hb_q) t_br <= cyc;
      if (!hblank && hb_q) begin
        blank_width <= cyc - t_br;
        t_bf <= cyc;
      end
      if (disp_en && !en_q) begin
        en_lag <= cyc - t_bf;
        t_er <= cyc;
      end
      if (!disp_en && en_q) en_width <= cyc - t_er;
    end
  end
endmodule

/* File: sim/crt_raster_timing_core_bench.sv */
// Self-checking bench: host port, line timing, row scan and frame length
`timescale 1ns/100ps
module crt_raster_timing_core_bench;
  import crt_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic char_ce = 1'b1;
  logic color_base_sel = 1'b1;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [15:0] ip = CRT_COLOR_INDEX_PORT;
  logic [15:0] dp = CRT_COLOR_DATA_PORT;
  logic [7:0] io_rdata, rd;
  logic hblank, hsync, disp_en;
  logic [4:0] row_scan, prev_row;
  logic [9:0] line_count;
  logic [1:0] pixel_shift_offset;
  logic [15:0] line_period, sync_width, en_width, blank_width, sync_lag, en_lag;
  int n_fail = 0;
  int samples_checked = 0;
  int steps, consec, nlines;
  logic ch, last_ch;

  crt_raster_timing_core #(.HCNT_W(9)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .char_ce(char_ce), .color_base_sel(color_base_sel), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .hblank(hblank), .hsync(hsync),
    .disp_en(disp_en), .row_scan(row_scan), .line_count(line_count),
    .pixel_shift_offset(pixel_shift_offset));
  crt_monitor_model mon (.ref_clk(ref_clk), .rst_n(rst_n), .hsync(hsync), .hblank(hblank),
    .disp_en(disp_en), .line_period(line_period), .sync_width(sync_width),
    .en_width(en_width), .blank_width(blank_width), .sync_lag(sync_lag), .en_lag(en_lag));

  always #4 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Host port and compare tasks
  // ----------------------------------------------------------------
  // One-cycle strobe launched at a falling edge; read data lands at the taking edge
  task automatic io_access(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = wr;
    io_rd = !wr;
    @(negedge ref_clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
    rd = io_rdata;
  endtask
  task automatic wr_reg(input logic [4:0] idx, input logic [7:0] v);
    io_access(1'b1, ip, {3'h0, idx});
    io_access(1'b1, dp, v);
  endtask
  task automatic rd_reg(input logic [4:0] idx);
    io_access(1'b1, ip, {3'h0, idx});
    io_access(1'b0, dp, 8'h00);
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s expected %0d seen %0d", nm, e, g);
      n_fail++;
    end
  endtask
  // Sample at the first falling edge after a retrace rise
  task automatic next_line();
    for (int k = 0; k < 200 && hsync === 1'b1; k++) @(negedge ref_clk);
    for (int k = 0; k < 200 && hsync !== 1'b1; k++) @(negedge ref_clk);
  endtask
  // A line count left above a new total runs on to its 10-bit wrap first
  task automatic to_frame();
    next_line();
    for (int k = 0; k < 1100 && line_count !== 10'h000; k++) next_line();
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 10; i++) wr_reg(5'(i), 8'hA0 + 8'(i));
    for (int i = 0; i < 10; i++) begin
      rd_reg(5'(i));
      chk8("timing reg", 8'hA0 + 8'(i), rd);
    end
    io_access(1'b1, ip, 8'hC3);
    io_access(1'b0, ip, 8'h00);
    chk8("index", 8'h03, rd);
    wr_reg(5'h0A, 8'h55);
    rd_reg(5'h0A);
    chk8("unmapped", CRT_READ_UNMAPPED, rd);
    // Monochrome base: colour data port must be deaf
    color_base_sel = 1'b0;
    ip = CRT_MONO_INDEX_PORT;
    dp = CRT_MONO_DATA_PORT;
    wr_reg(CRT_IDX_ACTIVE_END, 8'h3C);
    io_access(1'b1, CRT_COLOR_DATA_PORT, 8'h11);
    rd_reg(CRT_IDX_ACTIVE_END);
    chk8("mono base", 8'h3C, rd);
    color_base_sel = 1'b1;
    ip = CRT_COLOR_INDEX_PORT;
    dp = CRT_COLOR_DATA_PORT;
    // Protected writes, overflow bit 4 excepted
    wr_reg(CRT_IDX_SYNC_PROTECT, 8'h80);
    wr_reg(CRT_IDX_LINE_TOTAL, 8'h77);
    wr_reg(CRT_IDX_VERT_HIGH, 8'hFF);
    rd_reg(CRT_IDX_LINE_TOTAL);
    chk8("protected total", 8'hA0, rd);
    rd_reg(CRT_IDX_VERT_HIGH);
    chk8("overflow bit 4", 8'hB7, rd);
    wr_reg(CRT_IDX_SYNC_PROTECT, 8'h00);
    // A write without the character clock is lost
    char_ce = 1'b0;
    wr_reg(CRT_IDX_ROW_PRESET, 8'hFF);
    char_ce = 1'b1;
    rd_reg(CRT_IDX_ROW_PRESET);
    chk8("gated write", 8'hA8, rd);
    // Period 16; high at counts: enable 0..7, blank 10..14, raw retrace 11..13
    // A counter caught above the new total climbs to its wrap first, so wait longer once
    wr_reg(CRT_IDX_LINE_TOTAL, 8'h0B);
    wr_reg(CRT_IDX_ACTIVE_END, 8'h07);
    wr_reg(CRT_IDX_BLANK_START, 8'h09);
    wr_reg(CRT_IDX_SYNC_START, 8'h0A);
    for (int c = 0; c < 4; c++) begin
      wr_reg(CRT_IDX_SYNC_END, {1'b0, 2'(c), 5'h0D});
      wr_reg(CRT_IDX_BLANK_END, {1'b1, 2'(c), 5'h0E});
      repeat ((c == 0) ? 600 : 48) @(negedge ref_clk);
      chk16("line period", 16'd16, line_period);
      chk16("sync width", 16'd3, sync_width);
      chk16("blank width", 16'd5, blank_width);
      chk16("enable width", 16'd8, en_width);
      chk16("sync lag", 16'(1 + c), sync_lag);
      chk16("enable lag", 16'(1 + c), en_lag);
    end
    // Four-line frame, row height 2, preset 1
    wr_reg(CRT_IDX_FRAME_TOTAL, 8'h02);
    wr_reg(CRT_IDX_VERT_HIGH, 8'h00);
    wr_reg(CRT_IDX_ROW_PRESET, 8'h21);
    wr_reg(CRT_IDX_ROW_HEIGHT, 8'h01);
    // First zero may be the overflow wrap, which does not preset the row
    to_frame();
    to_frame();
    chk8("pan bits", 8'h01, {6'h00, pixel_shift_offset});
    for (int j = 0; j < 4; j++) begin
      chk8("line", 8'(j), line_count[7:0]);
      chk8("row", {7'h00, ~j[0]}, {3'h0, row_scan});
      next_line();
    end
    // Double scan: row never steps on two lines running
    wr_reg(CRT_IDX_FRAME_TOTAL, 8'h06);
    wr_reg(CRT_IDX_ROW_PRESET, 8'h00);
    wr_reg(CRT_IDX_ROW_HEIGHT, 8'h83);
    to_frame();
    chk8("preset row", 8'h00, {3'h0, row_scan});
    steps = 0;
    consec = 0;
    last_ch = 1'b0;
    for (int j = 1; j < 8; j++) begin
      prev_row = row_scan;
      next_line();
      ch = (row_scan !== prev_row);
      steps += int'(ch);
      consec += int'(ch && last_ch);
      last_ch = ch;
    end
    chk8("double scan pairs", 8'h00, 8'(consec));
    chk8("double scan steps", 8'h03, 8'(steps));
    // Frame total with overflow bit 8: 256 plus two gives 258 lines
    wr_reg(CRT_IDX_FRAME_TOTAL, 8'h00);
    wr_reg(CRT_IDX_VERT_HIGH, 8'h01);
    wr_reg(CRT_IDX_ROW_HEIGHT, 8'h00);
    to_frame();
    nlines = 0;
    for (int k = 0; k < 600 && (nlines == 0 || line_count !== 10'h000); k++) begin
      next_line();
      nlines++;
    end
    chk16("frame lines", 16'd258, 16'(nlines));
    conclude();
  end

  // Watchdog: the sequence needs under 30000 cycles, overflow wrap of the line count included
  initial begin
    #(8 * 40000);
    n_fail++;
    conclude();
  end
endmodule
